// File: sim/i2c_mode_config_and_own_address_tb.sv
`timescale 1ns/1ps
// compare two values, count and report a mismatch
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module i2c_mode_config_and_own_address_tb;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [imc_pkg::ADDR_W-1:0] avs_address;
  logic [imc_pkg::DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic mst_int_event, mst_scl_low, mst_sda_low;
  logic scl_out, scl_oe, sda_out, sda_oe, p_scl_low, p_sda_low;
  logic slv_addr_hit, slv_addressed, mst_int_raw;
  imc_pkg::imc_cfg_s cfg;
  int miscompares, tests_run, cyc, hits;
  // wired-and of the open-drain lines with a pull-up
  wire logic scl_w = ~((scl_oe & ~scl_out) | p_scl_low);
  wire logic sda_w = ~((sda_oe & ~sda_out) | p_sda_low);
  imc_config DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mst_int_event(mst_int_event),
    .mst_scl_low(mst_scl_low), .mst_sda_low(mst_sda_low), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .cfg(cfg), .mst_int_raw(mst_int_raw),
    .slv_addr_hit(slv_addr_hit), .slv_addressed(slv_addressed));
  imc_bus_peer PEER (.scl_low(p_scl_low), .sda_low(p_sda_low));
  // 125 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // count address hit pulses and cut a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (slv_addr_hit === 1'b1)
      hits++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end
  // verdict
  task automatic results();
  begin
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // one avalon transfer: hold until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] be);
  begin
    @(posedge sys_clk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask
  // read a register and compare
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
  begin
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
    `CHK(rd, e)
  end
  endtask
  // one address frame from the far side, hit count checked before the stop
  task automatic frame(input logic [7:0] b, input int e_hits, input logic e_adr);
  begin
    hits = 0;
    #3;
    PEER.start_cond();
    PEER.send_byte(b);
    `CHK(hits, e_hits)
    `CHK(slv_addressed, e_adr)
    PEER.stop_cond();
    repeat (4) @(posedge sys_clk);
    `CHK(slv_addressed, 1'b0)
  end
  endtask
  // master engine drive for loopback: set both lines, hold two cycles
  task automatic mstep(input logic c, input logic d);
  begin
    mst_scl_low <= c;
    mst_sda_low <= d;
    repeat (2) @(posedge sys_clk);
  end
  endtask
  // one address frame from the master engine, seen only through loopback
  task automatic mframe(input logic [7:0] b, input int e_hits);
  begin
    hits = 0;
    mstep(1'b0, 1'b1);
    mstep(1'b1, 1'b1);
    for (int i = 7; i >= 0; i--)
    begin
      mstep(1'b1, ~b[i]);
      mstep(1'b0, ~b[i]);
    end
    mstep(1'b1, 1'b1);
    `CHK(hits, e_hits)
    rd_chk(imc_pkg::OFS_STATUS, (e_hits == 1) ? 32'h0000_0002 : 32'h0000_0000);
    mstep(1'b0, 1'b1);
    mstep(1'b0, 1'b0);
    `CHK(slv_addressed, 1'b0)
  end
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    mst_int_event = 1'b0;
    mst_scl_low = 1'b0;
    mst_sda_low = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    `CHK(cfg, 11'h000)
    rd_chk(imc_pkg::OFS_OWN_ADDR, 32'h0000_0000);
    rd_chk(imc_pkg::OFS_ROLE_CFG, 32'h0000_0000);
    $display("test reset done");
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'hFFFF_FFFF, 4'hF);
    rd_chk(imc_pkg::OFS_ROLE_CFG, 32'h0000_0031);
    `CHK(cfg.internal_test_loop, 1'b1)
    mst_scl_low <= 1'b1;
    mst_sda_low <= 1'b1;
    @(posedge sys_clk);
    `CHK(scl_oe, 1'b0)
    `CHK(sda_oe, 1'b0)
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'h0000_0010, 4'hF);
    @(posedge sys_clk);
    `CHK(scl_oe, 1'b1)
    `CHK(sda_oe, 1'b1)
    `CHK({scl_out, sda_out}, 2'h0)
    `CHK(cfg.master_role_enable, 1'b1)
    `CHK(cfg.slave_role_enable, 1'b0)
    mst_scl_low <= 1'b0;
    mst_sda_low <= 1'b0;
    $display("test role config done");
    xfer(1'b1, imc_pkg::OFS_OWN_ADDR, 32'hFFFF_FF9D, 4'hF);
    xfer(1'b1, imc_pkg::OFS_OWN_ADDR, 32'h0000_0011, 4'h0);
    rd_chk(imc_pkg::OFS_OWN_ADDR, 32'h0000_001D);
    `CHK(cfg.own_bus_address, 7'h1D)
    rd_chk(6'h38, 32'h0000_0000);
    xfer(1'b1, imc_pkg::OFS_SLV_CTRL, 32'h0000_0001, 4'hF);
    rd_chk(imc_pkg::OFS_SLV_CTRL, 32'h0000_0000);
    `CHK(cfg.slave_operation_enable, 1'b1)
    $display("test address done");
    @(posedge sys_clk);
    mst_int_event <= 1'b1;
    @(posedge sys_clk);
    mst_int_event <= 1'b0;
    @(posedge sys_clk);
    `CHK(mst_int_raw, 1'b1)
    rd_chk(imc_pkg::OFS_STATUS, 32'h0000_0001);
    xfer(1'b1, imc_pkg::OFS_MINT_CLR, 32'h0000_0001, 4'hF);
    @(posedge sys_clk);
    `CHK(mst_int_raw, 1'b0)
    rd_chk(imc_pkg::OFS_MINT_CLR, 32'h0000_0000);
    mst_int_event <= 1'b1;
    xfer(1'b1, imc_pkg::OFS_MINT_CLR, 32'h0000_0001, 4'hF);
    mst_int_event <= 1'b0;
    @(posedge sys_clk);
    `CHK(mst_int_raw, 1'b1)
    xfer(1'b1, imc_pkg::OFS_MINT_CLR, 32'h0000_0001, 4'hF);
    rd_chk(imc_pkg::OFS_STATUS, 32'h0000_0000);
    $display("test interrupt clear done");
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'h0000_0020, 4'hF);
    frame(8'h3A, 1, 1'b1);
    frame(8'hB8, 0, 1'b0);
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'h0000_0000, 4'hF);
    frame(8'h3A, 0, 1'b0);
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'h0000_0020, 4'hF);
    xfer(1'b1, imc_pkg::OFS_SLV_CTRL, 32'h0000_0000, 4'hF);
    frame(8'h3A, 0, 1'b0);
    $display("test link match done");
    xfer(1'b1, imc_pkg::OFS_SLV_CTRL, 32'h0000_0001, 4'hF);
    xfer(1'b1, imc_pkg::OFS_ROLE_CFG, 32'h0000_0021, 4'hF);
    frame(8'h3A, 0, 1'b0);
    mframe(8'h3A, 1);
    mframe(8'hB8, 0);
    $display("test loopback done");
    results();
  end
endmodule

// File: sim/imc_bus_peer.sv
`timescale 1ns/1ps
// far-side bus master: pulls the open-drain lines low or lets the pull-up win
module imc_bus_peer (
  output logic scl_low,
  output logic sda_low
);
  // quarter of the 64 ns link clock period
  localparam int Q = 16;
  // idle: both lines released, the link clock stands still
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // start: data falls while the clock is high
  task automatic start_cond();
  begin
    sda_low = 1'b1;
    #(Q);
    scl_low = 1'b1;
    #(Q);
  end
  endtask
  // eight bits, most significant first, then a ninth clock with data released
  task automatic send_byte(input logic [7:0] b);
  begin
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      #(Q);
      scl_low = 1'b0;
      #(2*Q);
      scl_low = 1'b1;
      #(Q);
    end
    sda_low = 1'b0;
    #(Q);
    scl_low = 1'b0;
    #(2*Q);
    scl_low = 1'b1;
    #(Q);
  end
  endtask
  // stop: data rises while the clock is high, then both lines released
  task automatic stop_cond();
  begin
    sda_low = 1'b1;
    #(Q);
    scl_low = 1'b0;
    #(Q);
    sda_low = 1'b0;
    #(2*Q);
  end
  endtask
endmodule

// File: src/imc_addr_watch.sv
`timescale 1ns/1ps
module imc_addr_watch (
  input wire logic sys_clk,
  input wire logic rst,
  input imc_pkg::imc_line_s line,
  input wire logic enable,
  input wire logic [imc_pkg::OWN_W-1:0] own_bus_address,
  output logic addr_hit,
  output logic addressed
);
  imc_pkg::imc_line_s prev_r; // line levels one cycle back
  imc_pkg::imc_watch_e st_r;
  imc_pkg::imc_watch_e st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [imc_pkg::OWN_W:0] shift_r;
  logic [imc_pkg::OWN_W:0] shift_nxt;
  logic hit_r;
  logic hit_nxt;
  logic addressed_r;
  logic addressed_nxt;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;

  // bus conditions found from sampled edges of both bus lines
  assign start_cond = prev_r.scl && line.scl && prev_r.sda && !line.sda;
  assign stop_cond = prev_r.scl && line.scl && !prev_r.sda && line.sda;
  assign scl_rise = !prev_r.scl && line.scl;

  // next state of the address watcher
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    hit_nxt = 1'b0;
    addressed_nxt = addressed_r;
    if (!enable)
    begin
      // slave side off: back to idle and unaddressed, bit count and shift register kept
      st_nxt = imc_pkg::W_IDLE;
      addressed_nxt = 1'b0;
    end
    else if (start_cond)
    begin
      // start or repeated start opens an address phase
      st_nxt = imc_pkg::W_ADDR;
      cnt_nxt = imc_pkg::CNT_ZERO;
      addressed_nxt = 1'b0;
    end
    else if (stop_cond)
    begin
      st_nxt = imc_pkg::W_IDLE;
      addressed_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        imc_pkg::W_ADDR:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[imc_pkg::OWN_W-1:0], line.sda};
            cnt_nxt = cnt_r + imc_pkg::CNT_ONE;
            if (cnt_r == imc_pkg::ADDR_BITS_LAST)
            begin
              // first bit on the wire is the top address bit
              st_nxt = imc_pkg::W_BUSY;
              if (shift_r[imc_pkg::OWN_W-1:0] == own_bus_address)
              begin
                hit_nxt = 1'b1;
                addressed_nxt = 1'b1;
              end
            end
          end
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // registers of the address watcher
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // idle lines are high: no false edge right after reset
      prev_r <= '1;
      st_r <= imc_pkg::W_IDLE;
      cnt_r <= imc_pkg::CNT_ZERO;
      shift_r <= '0;
      hit_r <= 1'b0;
      addressed_r <= 1'b0;
    end
    else
    begin
      prev_r <= line;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      hit_r <= hit_nxt;
      addressed_r <= addressed_nxt;
    end
  end

  assign addr_hit = hit_r;
  assign addressed = addressed_r;

  // a hit always leaves the watcher addressed
  property p_hit_addressed;
    @(posedge sys_clk) disable iff (rst)
    addr_hit |-> addressed;
  endproperty
  a_hit_addressed: assert property (p_hit_addressed)
    else $error("address hit without addressed state");

  // disabling the slave role drops the addressed state next cycle
  property p_off_unaddressed;
    @(posedge sys_clk) disable iff (rst)
    !enable |=> !addressed;
  endproperty
  a_off_unaddressed: assert property (p_off_unaddressed)
    else $error("addressed while slave role disabled");
endmodule

// File: src/imc_config.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module imc_config (
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [imc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [imc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [imc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // master engine, same clock
  input wire logic mst_int_event,
  input wire logic mst_scl_low,
  input wire logic mst_sda_low,
  // open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // configuration, raw master interrupt and slave status
  output imc_pkg::imc_cfg_s cfg,
  output logic mst_int_raw,
  output logic slv_addr_hit,
  output logic slv_addressed
);
  imc_pkg::imc_cfg_s cfg_r; // live configuration
  imc_pkg::imc_cfg_s cfg_nxt;
  logic mint_r; // raw master interrupt
  logic mint_nxt;
  logic ack_r; // answer cycle of the bus
  logic ack_nxt;
  logic [imc_pkg::DATA_W-1:0] rdata_r;
  logic [imc_pkg::DATA_W-1:0] rdata_nxt;
  logic wr_go; // write takes effect this edge
  logic wr_lo; // byte lane holding all fields
  imc_pkg::imc_line_s pin_raw;
  imc_pkg::imc_line_s sync1_r;
  imc_pkg::imc_line_s sync2_r;
  imc_pkg::imc_line_s loop_line;
  imc_pkg::imc_line_s watch_line;
  logic watch_en;
  logic hit;
  logic addressed;

  // request is answered one cycle after it is raised
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go = avs_write && ack_r;
  assign wr_lo = wr_go && avs_byteenable[0];

  // next values of the register file
  always_comb
  begin
    cfg_nxt = cfg_r;
    mint_nxt = mint_r;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (wr_lo && avs_address == imc_pkg::OFS_OWN_ADDR)
    begin
      // own address field, low seven bits map to A6..A0
      cfg_nxt.own_bus_address = avs_writedata[imc_pkg::OWN_W-1:imc_pkg::OWN_LSB];
    end
    else if (wr_lo && avs_address == imc_pkg::OFS_SLV_CTRL)
    begin
      cfg_nxt.slave_operation_enable = avs_writedata[imc_pkg::BIT_SLV_OP];
    end
    else if (wr_lo && avs_address == imc_pkg::OFS_ROLE_CFG)
    begin
      // reserved bits of the write are dropped
      cfg_nxt.slave_role_enable = avs_writedata[imc_pkg::BIT_SLV_EN];
      cfg_nxt.master_role_enable = avs_writedata[imc_pkg::BIT_MST_EN];
      cfg_nxt.internal_test_loop = avs_writedata[imc_pkg::BIT_LOOP];
    end
    // raw interrupt: clear on write of one, a new event wins
    if (wr_lo && avs_address == imc_pkg::OFS_MINT_CLR && avs_writedata[imc_pkg::BIT_MINT])
    begin
      mint_nxt = 1'b0;
    end
    if (mst_int_event)
    begin
      mint_nxt = 1'b1;
    end
    // read data captured in the wait cycle, reserved bits read zero
    if (avs_read && !ack_r)
    begin
      rdata_nxt = imc_pkg::RD_ZERO;
      if (avs_address == imc_pkg::OFS_OWN_ADDR)
      begin
        rdata_nxt[imc_pkg::OWN_W-1:imc_pkg::OWN_LSB] = cfg_r.own_bus_address;
      end
      else if (avs_address == imc_pkg::OFS_ROLE_CFG)
      begin
        rdata_nxt[imc_pkg::BIT_SLV_EN] = cfg_r.slave_role_enable;
        rdata_nxt[imc_pkg::BIT_MST_EN] = cfg_r.master_role_enable;
        rdata_nxt[imc_pkg::BIT_LOOP] = cfg_r.internal_test_loop;
      end
      else if (avs_address == imc_pkg::OFS_STATUS)
      begin
        rdata_nxt[imc_pkg::BIT_MINT] = mint_r;
        rdata_nxt[imc_pkg::BIT_ADDRD] = addressed;
      end
      else
      begin
        // write-only, unmapped: zero
        rdata_nxt = imc_pkg::RD_ZERO;
      end
    end
  end

  // register file flip-flops
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_r.slave_role_enable <= imc_pkg::RST_BIT;
      cfg_r.master_role_enable <= imc_pkg::RST_BIT;
      cfg_r.internal_test_loop <= imc_pkg::RST_BIT;
      cfg_r.slave_operation_enable <= imc_pkg::RST_BIT;
      cfg_r.own_bus_address <= imc_pkg::RST_OWN_ADDR;
      mint_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= imc_pkg::RD_ZERO;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      mint_r <= mint_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // two-flop synchronisers on both bus lines
  assign pin_raw = '{scl: scl_in, sda: sda_in};
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // loopback feeds master drive straight to the slave side
  assign loop_line = '{scl: !mst_scl_low, sda: !mst_sda_low};
  assign watch_line = cfg_r.internal_test_loop ? loop_line : sync2_r;

  // pins only driven by an enabled master outside loopback
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = cfg_r.master_role_enable && !cfg_r.internal_test_loop && mst_scl_low;
  assign sda_oe = cfg_r.master_role_enable && !cfg_r.internal_test_loop && mst_sda_low;

  // slave answers only with both role and operation enabled
  assign watch_en = cfg_r.slave_role_enable && cfg_r.slave_operation_enable;

  imc_addr_watch u_watch (
    .sys_clk(sys_clk),
    .rst(rst),
    .line(watch_line),
    .enable(watch_en),
    .own_bus_address(cfg_r.own_bus_address),
    .addr_hit(hit),
    .addressed(addressed)
  );

  assign cfg = cfg_r;
  assign mst_int_raw = mint_r;
  assign avs_readdata = rdata_r;
  assign slv_addr_hit = hit;
  assign slv_addressed = addressed;

  // clearing write drops the raw flag unless an event lands
  property p_mint_clear;
    @(posedge sys_clk) disable iff (rst)
    (wr_lo && avs_address == imc_pkg::OFS_MINT_CLR && avs_writedata[imc_pkg::BIT_MINT]
      && !mst_int_event) |=> !mst_int_raw;
  endproperty
  a_mint_clear: assert property (p_mint_clear)
    else $error("raw interrupt not cleared");

  // an event sets the flag even during a clear
  property p_mint_set;
    @(posedge sys_clk) disable iff (rst)
    mst_int_event |=> mst_int_raw;
  endproperty
  a_mint_set: assert property (p_mint_set)
    else $error("interrupt event lost");

  // config write reaches the enables one edge later
  property p_cfg_write;
    @(posedge sys_clk) disable iff (rst)
    (wr_lo && avs_address == imc_pkg::OFS_ROLE_CFG) |=>
      (cfg.slave_role_enable == $past(avs_writedata[imc_pkg::BIT_SLV_EN])
      && cfg.master_role_enable == $past(avs_writedata[imc_pkg::BIT_MST_EN])
      && cfg.internal_test_loop == $past(avs_writedata[imc_pkg::BIT_LOOP]));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not applied");

  // loopback never drives the pins
  property p_loop_quiet;
    @(posedge sys_clk) disable iff (rst)
    cfg.internal_test_loop |-> (!scl_oe && !sda_oe);
  endproperty
  a_loop_quiet: assert property (p_loop_quiet)
    else $error("pin driven in loopback");

  // own address read returns the written value in bits 6:0
  property p_own_read;
    @(posedge sys_clk) disable iff (rst)
    (avs_read && !ack_r && avs_address == imc_pkg::OFS_OWN_ADDR) |=>
      (!avs_waitrequest && avs_readdata[imc_pkg::OWN_W-1:0] == $past(cfg.own_bus_address)
      && avs_readdata[imc_pkg::DATA_W-1:imc_pkg::OWN_W] == '0);
  endproperty
  a_own_read: assert property (p_own_read)
    else $error("own address read wrong");

  // reserved config bits always read as zero
  property p_cfg_reserved;
    @(posedge sys_clk) disable iff (rst)
    (avs_read && !ack_r && avs_address == imc_pkg::OFS_ROLE_CFG) |=>
      (avs_readdata[3:1] == 3'h0 && avs_readdata[imc_pkg::DATA_W-1:6] == '0);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("reserved config bits nonzero");

  // slave operation bit follows its write
  property p_slv_op;
    @(posedge sys_clk) disable iff (rst)
    (wr_lo && avs_address == imc_pkg::OFS_SLV_CTRL) |=>
      cfg.slave_operation_enable == $past(avs_writedata[imc_pkg::BIT_SLV_OP]);
  endproperty
  a_slv_op: assert property (p_slv_op)
    else $error("slave operation bit not applied");

  // reset leaves every role and the address cleared
  property p_reset_clear;
    @(posedge sys_clk)
    rst |=> (cfg == '0 && !scl_oe && !sda_oe);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("configuration not cleared by reset");

  // every request is answered after exactly one wait cycle
  property p_one_wait;
    @(posedge sys_clk) disable iff (rst)
    ((avs_read || avs_write) && !ack_r) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer timing wrong");

  // only an enabled master outside loopback pulls a pin low
  property p_oe_role;
    @(posedge sys_clk) disable iff (rst)
    (scl_oe || sda_oe) |-> (cfg.master_role_enable && !cfg.internal_test_loop);
  endproperty
  a_oe_role: assert property (p_oe_role)
    else $error("pin driven without master role");

  // no address hit while the slave side is switched off
  property p_slv_off;
    @(posedge sys_clk) disable iff (rst)
    !(cfg.slave_role_enable && cfg.slave_operation_enable) |=> !slv_addr_hit;
  endproperty
  a_slv_off: assert property (p_slv_off)
    else $error("address hit while slave side off");

  // own address write reaches the field one edge later
  property p_own_write;
    @(posedge sys_clk) disable iff (rst)
    (wr_lo && avs_address == imc_pkg::OFS_OWN_ADDR) |=>
      cfg.own_bus_address == $past(avs_writedata[imc_pkg::OWN_W-1:imc_pkg::OWN_LSB]);
  endproperty
  a_own_write: assert property (p_own_write)
    else $error("own address write not applied");

  // raw flag holds when neither an event nor a clear arrives
  property p_mint_hold;
    @(posedge sys_clk) disable iff (rst)
    (!mst_int_event && !(wr_lo && avs_address == imc_pkg::OFS_MINT_CLR
      && avs_writedata[imc_pkg::BIT_MINT])) |=> $stable(mst_int_raw);
  endproperty
  a_mint_hold: assert property (p_mint_hold)
    else $error("raw interrupt changed on its own");

  // read data stand until the next read is captured
  property p_rd_hold;
    @(posedge sys_clk) disable iff (rst)
    !(avs_read && !ack_r) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  // no request, no wait
  property p_wait_idle;
    @(posedge sys_clk) disable iff (rst)
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest without a request");
endmodule

// File: src/imc_pkg.sv
package imc_pkg;
  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int OWN_W = 7;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDR = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SLV_CTRL = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_MINT_CLR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_ROLE_CFG = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
  // field positions
  localparam int BIT_SLV_EN = 5;
  localparam int BIT_MST_EN = 4;
  localparam int BIT_LOOP = 0;
  localparam int BIT_SLV_OP = 0;
  localparam int BIT_MINT = 0;
  localparam int BIT_ADDRD = 1;
  localparam int OWN_LSB = 0;
  // reset values
  localparam logic [OWN_W-1:0] RST_OWN_ADDR = 7'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  // address phase: seven address bits then the direction bit
  localparam logic [3:0] ADDR_BITS_LAST = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // configuration handed to the rest of the controller
  typedef struct packed {
    logic slave_role_enable;
    logic master_role_enable;
    logic internal_test_loop;
    logic slave_operation_enable;
    logic [OWN_W-1:0] own_bus_address;
  } imc_cfg_s;

  // the two bus lines as seen by the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
  } imc_line_s;

  // address watcher states
  typedef enum logic [1:0] {W_IDLE, W_ADDR, W_BUSY} imc_watch_e;
endpackage
